// file: slc_pkg.sv
// Constants and types for the safety output and lockout controller
package slc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SLC_ADDR_CTRL       = 8'h00;
  localparam logic [7:0] SLC_ADDR_STATUS     = 8'h04;
  localparam logic [7:0] SLC_ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] SLC_ADDR_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] SLC_ADDR_IRQ_CLEAR  = 8'h10;

  localparam logic [2:0] SLC_IDX_CTRL       = 3'h0;
  localparam logic [2:0] SLC_IDX_STATUS     = 3'h1;
  localparam logic [2:0] SLC_IDX_IRQ_STATUS = 3'h2;
  localparam logic [2:0] SLC_IDX_IRQ_ENABLE = 3'h3;
  localparam logic [2:0] SLC_IDX_IRQ_CLEAR  = 3'h4;
  localparam logic [2:0] SLC_IDX_NONE       = 3'h7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SLC_CTRL_RELEASE_BIT = 0;
  localparam int SLC_STS_STATE_LSB    = 0;
  localparam int SLC_STS_FSO_LSB      = 2;
  localparam int SLC_STS_LRO_BIT      = 4;
  localparam int SLC_STS_TRIP_A_BIT   = 5;
  localparam int SLC_STS_TRIP_B_BIT   = 6;
  localparam int SLC_STS_CAUSE_LSB    = 8;

  localparam int SLC_NUM_CAUSE        = 5;
  localparam int SLC_NUM_EV           = 6;
  localparam int SLC_EV_FSO_WELD      = 0;
  localparam int SLC_EV_PRIMARY_WELD  = 1;
  localparam int SLC_EV_CHAN_DIFF     = 2;
  localparam int SLC_EV_EXT_LOCKOUT   = 3;
  localparam int SLC_EV_MODE_MISMATCH = 4;
  localparam int SLC_EV_TRIP          = 5;

  // ---------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [5:0]  SLC_IRQ_RESET   = 6'h00;
  localparam logic [31:0] SLC_DATA_RESET  = 32'h0000_0000;
  localparam logic        SLC_TRIP_RESET  = 1'h1;
  localparam logic [1:0]  SLC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SLC_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SLC_CLK_HZ          = 200_000_000;
  localparam int SLC_RESPONSE_MS     = 100;
  localparam int SLC_RESPONSE_CYCLES = SLC_RESPONSE_MS * (SLC_CLK_HZ / 1000);
  localparam int SLC_CNT_W           = 25;

  typedef enum logic [1:0] {
    SLC_LOCKED = 2'h1,
    SLC_RUN    = 2'h2
  } slc_state_type;

endpackage

// file: slc_trip_eval.sv
// One redundant channel of the final switch trip evaluation
`timescale 1ns/1ps
module slc_trip_eval
  import slc_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Sensor conditions
  input  wire logic beam_interrupted,
  input  wire logic sensor_fault,
  input  wire logic ambient_excess,
  input  wire logic cable_fault,
  input  wire logic forced_output_off_input,
  input  wire logic muting,
  // Result
  output logic      trip_q
);

  logic trip_d;

  always_comb begin
    trip_d = forced_output_off_input;
    if (!muting) begin
      trip_d = trip_d | beam_interrupted;
      trip_d = trip_d | sensor_fault;
      trip_d = trip_d | ambient_excess;
      trip_d = trip_d | cable_fault;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_q <= SLC_TRIP_RESET;
    end else begin
      trip_q <= trip_d;
    end
  end

endmodule

// file: slc_relay_monitor.sv
// Watches two relays for feedback that disagrees with the command
`timescale 1ns/1ps
module slc_relay_monitor
  import slc_pkg::*;
#(
  parameter int LIMIT = SLC_RESPONSE_CYCLES
)(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Command and feedback
  input  wire logic [1:0] expect_closed,
  input  wire logic [1:0] seen_closed,
  // Findings
  output logic            stuck_closed_q,
  output logic            stuck_open_q
);

  localparam logic [SLC_CNT_W-1:0] LIM = SLC_CNT_W'(LIMIT);

  logic [SLC_CNT_W-1:0] cnt_q [2];
  logic [SLC_CNT_W-1:0] cnt_d [2];
  logic                 stuck_closed_d;
  logic                 stuck_open_d;

  // Disagreement must outlast the relay response bound
  always_comb begin
    stuck_closed_d = 1'b0;
    stuck_open_d   = 1'b0;
    for (int i = 0; i < 2; i++) begin
      cnt_d[i] = '0;
      if (expect_closed[i] != seen_closed[i]) begin
        cnt_d[i] = cnt_q[i];
        if (cnt_q[i] != LIM) begin
          cnt_d[i] = cnt_q[i] + 1'b1;
        end else begin
          stuck_closed_d = stuck_closed_d | seen_closed[i];
          stuck_open_d   = stuck_open_d | ~seen_closed[i];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        cnt_q[i] <= '0;
      end
      stuck_closed_q <= 1'b0;
      stuck_open_q   <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
      stuck_closed_q <= stuck_closed_d;
      stuck_open_q   <= stuck_open_d;
    end
  end

endmodule

// file: slc_top.sv
// Safety light curtain output and lockout controller with AXI4-Lite registers
//
// What this block does
// - Beam interruption opens outputs unless muted
// - Sensor failure opens outputs unless muted
// - Excess ambient light opens outputs unless muted
// - Cable break or short opens outputs unless muted
// - Forced-off input opens outputs even muted
// - Two final switch outputs, opened on trips
// - Lockout output open at power-up
// - Final switch relay weld opens lockout
// - Primary relay weld opens lockout
// - Dual channel disagreement opens lockout
// - Open external lockout input opens lockout
// - Primary contact mode mismatch opens lockout
// - Lockout opens secondary relay circuit
// - Relay actions compared, inconsistencies reported
// - Muting input suppresses sensor trips
`timescale 1ns/1ps
module slc_top
  import slc_pkg::*;
#(
  parameter int RESPONSE_CYCLES = SLC_RESPONSE_CYCLES
)(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sensor conditions, channel A
  input  wire logic        beam_interrupted_a,
  input  wire logic        sensor_fault_a,
  input  wire logic        ambient_excess_a,
  input  wire logic        cable_fault_a,
  // Sensor conditions, channel B
  input  wire logic        beam_interrupted_b,
  input  wire logic        sensor_fault_b,
  input  wire logic        ambient_excess_b,
  input  wire logic        cable_fault_b,
  // Overrides
  input  wire logic        forced_output_off_input,
  input  wire logic        muting_input,
  // Lockout inputs
  input  wire logic        ext_lockout_closed,
  input  wire logic        lockout_release_input,
  input  wire logic        primary_mode_nc,
  // Relay feedback
  input  wire logic [1:0]  final_switch_fb,
  input  wire logic [1:0]  primary_machine_relays_fb,
  // Relay drives and interrupt
  output logic [1:0]       final_switch_outputs,
  output logic             lockout_relay_output,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  slc_state_type        state_q;
  slc_state_type        state_d;
  logic [1:0]           fso_q;
  logic [1:0]           fso_d;
  logic                 lro_q;
  logic                 lro_d;
  logic                 release_prev_q;
  logic                 release_prev_d;
  logic                 release_evt;
  logic                 trip_a;
  logic                 trip_b;
  logic                 fso_stuck_closed;
  logic                 fso_stuck_open;
  logic                 pri_stuck_closed;
  logic                 pri_stuck_open;
  logic [1:0]           pri_seen_closed;
  logic [SLC_NUM_CAUSE-1:0] cause;
  logic                 cause_any;
  logic [SLC_NUM_EV-1:0] ev;
  logic [SLC_NUM_EV-1:0] irq_status_q;
  logic [SLC_NUM_EV-1:0] irq_status_d;
  logic [SLC_NUM_EV-1:0] irq_enable_q;
  logic [SLC_NUM_EV-1:0] irq_enable_d;
  logic [SLC_NUM_EV-1:0] irq_clear;
  logic                 irq_q;
  logic                 irq_d;
  logic                 sw_release;
  logic                 awready_q;
  logic                 awready_d;
  logic                 wready_q;
  logic                 wready_d;
  logic                 aw_got_q;
  logic                 aw_got_d;
  logic                 w_got_q;
  logic                 w_got_d;
  logic [7:0]           awaddr_q;
  logic [7:0]           awaddr_d;
  logic [31:0]          wdata_q;
  logic [31:0]          wdata_d;
  logic [3:0]           wstrb_q;
  logic [3:0]           wstrb_d;
  logic                 bvalid_q;
  logic                 bvalid_d;
  logic [1:0]           bresp_q;
  logic [1:0]           bresp_d;
  logic                 arready_q;
  logic                 arready_d;
  logic                 rvalid_q;
  logic                 rvalid_d;
  logic [31:0]          rdata_q;
  logic [31:0]          rdata_d;
  logic [1:0]           rresp_q;
  logic [1:0]           rresp_d;
  logic                 wr_do;
  logic [2:0]           wr_idx;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    logic [2:0] idx;
    idx = SLC_IDX_NONE;
    case (addr)
      SLC_ADDR_CTRL:       idx = SLC_IDX_CTRL;
      SLC_ADDR_STATUS:     idx = SLC_IDX_STATUS;
      SLC_ADDR_IRQ_STATUS: idx = SLC_IDX_IRQ_STATUS;
      SLC_ADDR_IRQ_ENABLE: idx = SLC_IDX_IRQ_ENABLE;
      SLC_ADDR_IRQ_CLEAR:  idx = SLC_IDX_IRQ_CLEAR;
      default:             idx = SLC_IDX_NONE;
    endcase
    return idx;
  endfunction

  // ---------------------------------------------------------------
  // Redundant trip channels
  // ---------------------------------------------------------------
  slc_trip_eval u_chan_a (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .beam_interrupted        (beam_interrupted_a),
    .sensor_fault            (sensor_fault_a),
    .ambient_excess          (ambient_excess_a),
    .cable_fault             (cable_fault_a),
    .forced_output_off_input (forced_output_off_input),
    .muting                  (muting_input),
    .trip_q                  (trip_a)
  );

  slc_trip_eval u_chan_b (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .beam_interrupted        (beam_interrupted_b),
    .sensor_fault            (sensor_fault_b),
    .ambient_excess          (ambient_excess_b),
    .cable_fault             (cable_fault_b),
    .forced_output_off_input (forced_output_off_input),
    .muting                  (muting_input),
    .trip_q                  (trip_b)
  );

  // ---------------------------------------------------------------
  // Relay monitors
  // ---------------------------------------------------------------
  assign pri_seen_closed = primary_machine_relays_fb ^ {2{primary_mode_nc}};

  slc_relay_monitor #(.LIMIT(RESPONSE_CYCLES)) u_fso_mon (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .expect_closed  (fso_q),
    .seen_closed    (final_switch_fb),
    .stuck_closed_q (fso_stuck_closed),
    .stuck_open_q   (fso_stuck_open)
  );

  slc_relay_monitor #(.LIMIT(RESPONSE_CYCLES)) u_pri_mon (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .expect_closed  (fso_q),
    .seen_closed    (pri_seen_closed),
    .stuck_closed_q (pri_stuck_closed),
    .stuck_open_q   (pri_stuck_open)
  );

  // ---------------------------------------------------------------
  // Lockout causes and state
  // ---------------------------------------------------------------
  always_comb begin
    cause = '0;
    cause[SLC_EV_FSO_WELD]      = fso_stuck_closed | fso_stuck_open;
    cause[SLC_EV_PRIMARY_WELD]  = pri_stuck_closed;
    cause[SLC_EV_CHAN_DIFF]     = trip_a ^ trip_b;
    cause[SLC_EV_EXT_LOCKOUT]   = ~ext_lockout_closed;
    cause[SLC_EV_MODE_MISMATCH] = pri_stuck_open;
    cause_any   = |cause;
    release_evt = (lockout_release_input & ~release_prev_q) | sw_release;
  end

  always_comb begin
    state_d        = state_q;
    release_prev_d = lockout_release_input;
    case (state_q)
      SLC_LOCKED: begin
        if (release_evt && !cause_any) begin
          state_d = SLC_RUN;
        end
      end
      SLC_RUN: begin
        if (cause_any) begin
          state_d = SLC_LOCKED;
        end
      end
      default: state_d = SLC_LOCKED;
    endcase
    lro_d = (state_d == SLC_RUN);
    fso_d = {2{(state_d == SLC_RUN) & ~trip_a & ~trip_b}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q        <= SLC_LOCKED;
      lro_q          <= 1'b0;
      fso_q          <= 2'h0;
      release_prev_q <= 1'b1;
    end else begin
      state_q        <= state_d;
      lro_q          <= lro_d;
      fso_q          <= fso_d;
      release_prev_q <= release_prev_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt registers
  // ---------------------------------------------------------------
  always_comb begin
    ev = {fso_q[0] & ~fso_d[0], cause};
    irq_clear  = '0;
    sw_release = 1'b0;
    irq_enable_d = irq_enable_q;
    if (wr_do && wstrb_q[0]) begin
      case (wr_idx)
        SLC_IDX_CTRL:       sw_release = wdata_q[SLC_CTRL_RELEASE_BIT];
        SLC_IDX_IRQ_ENABLE: irq_enable_d = wdata_q[SLC_NUM_EV-1:0];
        SLC_IDX_IRQ_CLEAR:  irq_clear = wdata_q[SLC_NUM_EV-1:0];
        default:            irq_clear = '0;
      endcase
    end
    irq_status_d = (irq_status_q & ~irq_clear) | ev;
    irq_d = |(irq_status_d & irq_enable_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= SLC_IRQ_RESET;
      irq_enable_q <= SLC_IRQ_RESET;
      irq_q        <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      irq_q        <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  assign wr_do  = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_idx = reg_index(awaddr_q);

  always_comb begin
    awready_d = awready_q;
    wready_d  = wready_q;
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      awready_d = 1'b0;
      aw_got_d  = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      wready_d = 1'b0;
      w_got_d  = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = (wr_idx == SLC_IDX_NONE) ? SLC_RESP_SLVERR : SLC_RESP_OKAY;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= SLC_DATA_RESET;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= SLC_RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = SLC_DATA_RESET;
      rresp_d   = SLC_RESP_OKAY;
      case (reg_index(s_axi_araddr))
        SLC_IDX_STATUS: begin
          rdata_d[SLC_STS_STATE_LSB +: 2] = state_q;
          rdata_d[SLC_STS_FSO_LSB +: 2]   = fso_q;
          rdata_d[SLC_STS_LRO_BIT]        = lro_q;
          rdata_d[SLC_STS_TRIP_A_BIT]     = trip_a;
          rdata_d[SLC_STS_TRIP_B_BIT]     = trip_b;
          rdata_d[SLC_STS_CAUSE_LSB +: SLC_NUM_CAUSE] = cause;
        end
        SLC_IDX_IRQ_STATUS: rdata_d[SLC_NUM_EV-1:0] = irq_status_q;
        SLC_IDX_IRQ_ENABLE: rdata_d[SLC_NUM_EV-1:0] = irq_enable_q;
        SLC_IDX_CTRL:       rdata_d = SLC_DATA_RESET;
        SLC_IDX_IRQ_CLEAR:  rdata_d = SLC_DATA_RESET;
        default:            rresp_d = SLC_RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= SLC_DATA_RESET;
      rresp_q   <= SLC_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready        = awready_q;
  assign s_axi_wready         = wready_q;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = arready_q;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rdata          = rdata_q;
  assign s_axi_rresp          = rresp_q;
  assign final_switch_outputs = fso_q;
  assign lockout_relay_output = lro_q;
  assign irq                  = irq_q;

endmodule

// file: slc_relay_model.sv
// Machine relay model: two primary relays and final switch readback
`timescale 1ns/1ps
module slc_relay_model (
  // Drive and fault controls
  input  wire logic       aclk,
  input  wire logic [1:0] cmd,
  input  wire logic       slow,
  input  wire logic [1:0] weld,
  // Contact readback
  output logic      [1:0] fs_fb,
  output logic      [1:0] pm_fb
);
  logic [7:0][1:0] dly_q;
  logic [1:0]      pos;

  always_ff @(posedge aclk) dly_q <= {dly_q[6:0], cmd};
  // Prompt or slow answer, both inside the bound
  assign pos   = slow ? dly_q[7] : dly_q[0];
  // Two primary relays; weld[1] welds the second one, weld[0] welds final switch relay 0
  assign fs_fb = pos | {1'h0, weld[0]};
  assign pm_fb = pos | {weld[1], 1'h0};
endmodule

// file: slc_top_assertions.sv
// Port checker for the lockout controller
`timescale 1ns/1ps
module slc_top_assertions (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Inputs watched
  input wire logic       beam_interrupted_a,
  input wire logic       sensor_fault_a,
  input wire logic       forced_output_off_input,
  input wire logic       muting_input,
  input wire logic       ext_lockout_closed,
  input wire logic       lockout_release_input,
  input wire logic       s_axi_bvalid,
  // Relay drives
  input wire logic [1:0] final_switch_outputs,
  input wire logic       lockout_relay_output
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_open;
    ##2 final_switch_outputs == 2'h0;
  endsequence

  AST_BEAM: assert property (beam_interrupted_a && !muting_input |-> s_open)
    else $error("beam left outputs closed");
  AST_SENSE: assert property (sensor_fault_a && !muting_input |-> s_open)
    else $error("sensor failure left outputs closed");
  AST_FORCED: assert property (forced_output_off_input |-> s_open)
    else $error("forced off left outputs closed");
  AST_PAIR: assert property (final_switch_outputs[0] == final_switch_outputs[1])
    else $error("final switch outputs differ");
  AST_RESET: assert property ($rose(aresetn) |-> !lockout_relay_output)
    else $error("lockout closed at power up");
  AST_EXT: assert property (!ext_lockout_closed |-> ##[1:2] !lockout_relay_output)
    else $error("external lockout ignored");
  AST_LOCK: assert property (!lockout_relay_output |-> final_switch_outputs == 2'h0)
    else $error("outputs closed while locked");
  AST_LATCH: assert property ($rose(lockout_relay_output) |->
    $past(lockout_release_input) || $past(s_axi_bvalid) || s_axi_bvalid)
    else $error("lockout left without release");
endmodule

bind slc_top slc_top_assertions u_chk (.aclk, .aresetn, .beam_interrupted_a,
  .sensor_fault_a, .forced_output_off_input, .muting_input, .ext_lockout_closed,
  .lockout_release_input, .s_axi_bvalid, .final_switch_outputs, .lockout_relay_output);

// file: slc_top_tb.sv
// Bench for the safety output and lockout controller
`timescale 1ns/1ps
module slc_top_tb
  import slc_pkg::*;
;
  localparam int RC = 16;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, forced_output_off_input, muting_input, ext_lockout_closed;
  logic lockout_release_input, primary_mode_nc, lockout_relay_output, irq, slow;
  logic beam_a, beam_b, fault, ambient, cable;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, final_switch_fb, final_switch_outputs;
  logic [1:0] primary_machine_relays_fb, weld;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, v;
  logic [2:0] codes [3] = '{3'h2, 3'h4, 3'h1};
  int err_count, check_count, i, seed;

  slc_top #(.RESPONSE_CYCLES(RC)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .beam_interrupted_a(beam_a), .sensor_fault_a(fault), .ambient_excess_a(ambient),
    .cable_fault_a(cable), .beam_interrupted_b(beam_b), .sensor_fault_b(fault),
    .ambient_excess_b(ambient), .cable_fault_b(cable), .forced_output_off_input,
    .muting_input, .ext_lockout_closed, .lockout_release_input, .primary_mode_nc,
    .final_switch_fb, .primary_machine_relays_fb, .final_switch_outputs,
    .lockout_relay_output, .irq);
  slc_relay_model model (.aclk, .cmd(final_switch_outputs), .slow, .weld,
    .fs_fb(final_switch_fb), .pm_fb(primary_machine_relays_fb));

  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    {rdat, resp} = {s_axi_rdata, s_axi_rresp};
  endtask
  task automatic rel();
    @(posedge aclk);
    lockout_release_input <= 1'h1;
    cyc(3);
    lockout_release_input <= 1'h0;
    cyc(3);
  endtask
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'h0;
    cyc(10);
    aresetn <= 1'h1;
    cyc(2);
  endtask
  function automatic logic [31:0] fso_exp(input logic [31:0] r);
    return (r[4] && r[5]) || (!r[6] && |r[3:0]) ? 32'h0 : 32'h3;
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    cyc(5000);
    err_count++;
    results();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, weld, slow} = '0;
    {beam_a, beam_b, fault, ambient, cable, forced_output_off_input, muting_input} = '0;
    {lockout_release_input, primary_mode_nc, err_count, check_count} = '0;
    ext_lockout_closed = 1'h1;
    seed = 32'h53D72768;
    rst();
    chk("reset lockout", 32'h0, 32'(lockout_relay_output));
    rd(SLC_ADDR_STATUS);
    chk("status", 32'h1, rdat & 32'h1F);
    rd(SLC_ADDR_IRQ_ENABLE);
    chk("irq enable", 32'(SLC_IRQ_RESET), rdat);
    rd(8'h1C);
    chk("unmapped read", 32'(SLC_RESP_SLVERR), 32'(resp));
    wr(8'h1C, 32'h1);
    chk("unmapped write", 32'(SLC_RESP_SLVERR), 32'(resp));
    rel();
    chk("release", 32'h7, 32'({lockout_relay_output, final_switch_outputs}));
    for (i = 0; i < 32; i++) begin
      v = (i == 0) ? 32'h71 : (i == 1) ? 32'h41 : $random(seed);
      @(posedge aclk);
      {beam_a, beam_b, fault, ambient, cable} <= {v[0], v[0], v[3:1]};
      {forced_output_off_input, muting_input, slow} <= {v[4] & v[5], v[6], v[7]};
      cyc(4);
      chk("outputs", fso_exp(v), 32'(final_switch_outputs));
      cyc(10);
      chk("lockout held", 32'h1, 32'(lockout_relay_output));
    end
    {beam_a, beam_b, fault, ambient, cable, forced_output_off_input, muting_input} <= '0;
    cyc(12);
    beam_b <= 1'h1;
    cyc(6);
    chk("channel diff", 32'h0, 32'(lockout_relay_output));
    beam_b <= 1'h0;
    ext_lockout_closed <= 1'h0;
    cyc(10);
    rel();
    chk("refused release", 32'h0, 32'(lockout_relay_output));
    ext_lockout_closed <= 1'h1;
    rel();
    chk("key release", 32'h1, 32'(lockout_relay_output));
    for (i = 0; i < 3; i++) begin
      @(posedge aclk);
      {weld, primary_mode_nc, beam_a, beam_b} <= {codes[i], 2'h3};
      cyc(RC + 16);
      chk("relay fault", 32'h0, 32'(lockout_relay_output));
      {weld, primary_mode_nc, beam_a, beam_b} <= 5'h0;
      cyc(12);
      rel();
      chk("fault release", 32'h1, 32'(lockout_relay_output));
    end
    wr(SLC_ADDR_IRQ_ENABLE, 32'h8);
    ext_lockout_closed <= 1'h0;
    cyc(4);
    chk("irq raised", 32'h1, 32'(irq));
    rd(SLC_ADDR_IRQ_STATUS);
    chk("irq status", 32'h8, rdat & 32'h8);
    wr(SLC_ADDR_IRQ_ENABLE, 32'h0);
    cyc(2);
    chk("irq masked", 32'h0, 32'(irq));
    ext_lockout_closed <= 1'h1;
    wr(SLC_ADDR_IRQ_ENABLE, 32'h8);
    wr(SLC_ADDR_IRQ_CLEAR, 32'h8);
    cyc(2);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(SLC_ADDR_CTRL, 32'h1);
    cyc(3);
    chk("register release", 32'h1, 32'(lockout_relay_output));
    rst();
    chk("power return", 32'h0, 32'(lockout_relay_output));
    results();
  end
endmodule
